// ---- core/lss_list_step_sequencer.sv ----
// List step sequencer: steps source points through one of nine stored lists.
// Assumes APB master on core_clk, synchronous trigger and sample inputs.
// Operation
// [RULE_01] List index 1..9 selects a stored list; index 0 runs the demonstration list.
// [RULE_02] Time hold keeps each step until its dwell time elapses.
// [RULE_03] Point hold keeps each step until its sample count is reached.
// [RULE_04] Zero-on-finish leaves 0 V and 0.1 A; otherwise the last values stay.
// [RULE_05] Step mode advances exactly one step per accepted trigger.
// [RULE_06] Step mode pulses measure complete on line 2 after each step.
// [RULE_07] Sweep mode runs every step per trigger, one pulse per list cycle.
// [RULE_08] The whole list repeats the programmed cycle count times.
// [RULE_09] Output switched off aborts a running list at once.
// [RULE_10] Local start forces immediate trigger, counts from list, continuous off.
// [RULE_11] Finished list returns idle; a new trigger restarts from the beginning.
// [RULE_12] Time hold measurement window is dwell minus source delay.
// [RULE_13] Time hold sample count is window divided by sampling period.
// [RULE_14] Point hold measure time is samples times period; dwell ignored.
// [RULE_15] Immediate triggering starts the next step right after measure complete.
// [RULE_16] Other triggers need measure complete and then a trigger-in event.
// [RULE_17] Triggers during delay, measurement or dwell are discarded.
// [RULE_18] Measured value over the abort limit stops the list.
// [RULE_19] Abort command ends all list activity and stops the sequence.
// [RULE_20] Autozero adds reference and zero readings before each measurement.
// [RULE_21] Reset leaves idle, pulse low, all counters cleared.
// [RULE_22] Measure complete is one clock cycle wide per event.
`timescale 1ns/10ps
`include "lss_params.svh"
module lss_list_step_sequencer (
	// Clock, reset, enable
	input wire logic core_clk,
	input wire logic rst,
	input wire logic clk_en,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Front panel and outside events
	input wire logic local_start,
	input wire logic output_on,
	input wire logic trig_in,
	input wire logic sample_tick,
	input wire logic [15:0] meas_value,
	// Source and digital I/O line 2
	output lss_pkg::lss_src_s src_out,
	output logic meas_done,
	output logic running,
	output logic [1:0] eff_trig_src,
	output logic cont_init
);
	////////////////////////////////////////////////////////////////////////////////
	// Configuration registers
	logic sweep_ff, hold_mode_select_ff, zero_end_ff, az_ff;
	lss_pkg::lss_trig_e tsrc_ff;
	logic [3:0] list_ff;
	logic [`LSS_CYC_W-1:0] cyc_cfg_ff;
	logic [`LSS_TIME_W-1:0] sdly_ff;
	logic [`LSS_SMP_W-1:0] sprd_ff;
	logic [15:0] limit_ff;
	logic [`LSS_TIME_W-1:0] az_time_ff;
	logic [`LSS_PNT_W-1:0] pnts_ff [0:9];
	// Step memory per list entry: volt, ilim, dwell, samples
	logic [31:0] mem_src [0:`LSS_MEM_DEPTH*10-1];
	logic [31:0] mem_tim [0:`LSS_MEM_DEPTH*10-1];
	logic sw_start, sw_abort, apb_hit, apb_wr;
	logic [11:0] mem_idx;
	////////////////////////////////////////////////////////////////////////////////
	// Sequencer state
	lss_pkg::lss_state_e st_ff;
	logic [`LSS_PNT_W-1:0] step_ff;
	logic [`LSS_CYC_W-1:0] cyc_ff;
	logic [`LSS_TIME_W-1:0] tmr_ff;
	logic [`LSS_SMP_W-1:0] smp_ff;
	logic [`LSS_SMP_W-1:0] smp_goal_ff;
	logic [`LSS_TIME_W-1:0] dwell_ff;
	logic local_ff;
	logic [11:0] cur_idx;
	logic [`LSS_PNT_W-1:0] npts;
	logic last_step, stop_req;
	logic [`LSS_TIME_W-1:0] win_time;
	// Demo list sits in slot 0; indices above nine fall back to it
	// [RULE_01] List index select
	assign cur_idx = 12'((list_ff > `LSS_LIST_MAX) ? 0 : list_ff) * 12'd`LSS_MEM_DEPTH + 12'(step_ff);
	assign npts = pnts_ff[(list_ff > `LSS_LIST_MAX) ? 4'h0 : list_ff];
	assign last_step = (step_ff + 8'h01 >= npts);
	assign apb_hit = psel & penable;
	assign apb_wr = apb_hit & pwrite;
	assign sw_start = apb_wr && paddr == `LSS_ADDR_CTRL && pwdata[`LSS_CTRL_START];
	assign sw_abort = apb_wr && paddr == `LSS_ADDR_CTRL && pwdata[`LSS_CTRL_ABORT];
	assign mem_idx = paddr[11:2] & 12'h3FF;
	// [RULE_12] Window is dwell minus source delay
	assign win_time = (dwell_ff > sdly_ff) ? dwell_ff - sdly_ff : 24'h00_0000;
	// [RULE_09] Output off, limit and abort stop
	// [RULE_18] Limit exceed stop
	// [RULE_19] Abort command stop
	assign stop_req = sw_abort | ~output_on | (st_ff == lss_pkg::lss_st_meas && sample_tick && meas_value > limit_ff);
	////////////////////////////////////////////////////////////////////////////////
	// APB config writes; zero-wait slave, unmapped reads zero, with error only above 0x040 and below 0x400
	always_ff @(posedge core_clk) begin
		if (rst) begin
			sweep_ff <= 1'b0;
			hold_mode_select_ff <= 1'b0;
			zero_end_ff <= 1'b0;
			az_ff <= 1'b0;
			tsrc_ff <= lss_pkg::lss_trig_imm;
			list_ff <= `LSS_LIST_DEMO;
			cyc_cfg_ff <= 16'h0001;
			sdly_ff <= 24'h00_0000;
			sprd_ff <= 16'h0001;
			limit_ff <= 16'hFFFF;
			az_time_ff <= 24'h00_0000;
		end else if (clk_en && apb_wr) begin
			unique case (paddr)
				`LSS_ADDR_CFG: begin
					sweep_ff <= pwdata[`LSS_CFG_SWEEP];
					hold_mode_select_ff <= pwdata[`LSS_CFG_HOLD];
					zero_end_ff <= pwdata[`LSS_CFG_ZERO];
					az_ff <= pwdata[`LSS_CFG_AZ];
					tsrc_ff <= lss_pkg::lss_trig_e'(pwdata[`LSS_CFG_TSRC_LO +: 2]);
					list_ff <= pwdata[`LSS_CFG_LIST_LO +: 4];
					cyc_cfg_ff <= pwdata[`LSS_CFG_CYC_LO +: 16];
				end
				`LSS_ADDR_SDLY: sdly_ff <= pwdata[23:0];
				`LSS_ADDR_SPRD: sprd_ff <= (pwdata[15:0] == 16'h0000) ? 16'h0001 : pwdata[15:0];
				`LSS_ADDR_LIMIT: limit_ff <= pwdata[15:0];
				`LSS_ADDR_AZ: az_time_ff <= pwdata[23:0];
				default: begin
				end
			endcase
		end
	end
	// Point counts per list, one word per list at PNTS + 4*list
	generate
		for (genvar i = 0; i < 10; i++) begin : g_pnts
			always_ff @(posedge core_clk) begin
				if (rst) begin
					pnts_ff[i] <= 8'h01;
				end else if (clk_en && apb_wr && paddr == `LSS_ADDR_PNTS + 12'(4*i)) begin
					pnts_ff[i] <= (pwdata[7:0] == 8'h00) ? 8'h01 : pwdata[7:0];
				end
			end
		end
	endgenerate
	// Step memory: address bit 2 picks source or timing word, no reset needed
	always_ff @(posedge core_clk) begin
		if (clk_en && apb_wr && paddr >= `LSS_ADDR_STEP) begin
			if (paddr[2]) begin
				mem_tim[(mem_idx - 12'h100) >> 1] <= pwdata;
			end else begin
				mem_src[(mem_idx - 12'h100) >> 1] <= pwdata;
			end
		end
	end
	// Read mux and answer
	always_ff @(posedge core_clk) begin
		if (rst) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else if (clk_en) begin
			pready <= psel & ~penable;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
			if (psel && !penable && !pwrite) begin
				unique case (paddr)
					`LSS_ADDR_CFG: prdata <= {cyc_cfg_ff, 4'h0, list_ff, 2'b00, tsrc_ff, az_ff, zero_end_ff,
						hold_mode_select_ff, sweep_ff};
					`LSS_ADDR_SDLY: prdata <= {8'h00, sdly_ff};
					`LSS_ADDR_SPRD: prdata <= {16'h0000, sprd_ff};
					`LSS_ADDR_LIMIT: prdata <= {16'h0000, limit_ff};
					`LSS_ADDR_STAT: prdata <= {cyc_ff, step_ff, 4'h0, 1'b0, 3'(st_ff)};
					`LSS_ADDR_AZ: prdata <= {8'h00, az_time_ff};
					`LSS_ADDR_CTRL: prdata <= 32'h0000_0000;
					default: pslverr <= paddr < `LSS_ADDR_STEP && paddr > `LSS_ADDR_PNTS + 12'h024;
				endcase
			end
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// Sequencer state machine
	always_ff @(posedge core_clk) begin
		if (rst) begin
			// [RULE_21] Reset clears everything
			st_ff <= lss_pkg::lss_st_idle;
			step_ff <= 8'h00;
			cyc_ff <= 16'h0000;
			tmr_ff <= 24'h00_0000;
			smp_ff <= 16'h0000;
			smp_goal_ff <= 16'h0000;
			dwell_ff <= 24'h00_0000;
			local_ff <= 1'b0;
		end else if (clk_en) begin
			if (stop_req && st_ff != lss_pkg::lss_st_idle) begin
				st_ff <= lss_pkg::lss_st_idle;
			end else begin
				unique case (st_ff)
					lss_pkg::lss_st_idle: begin
						// [RULE_11] Restart from first step
						if ((sw_start || local_start) && output_on) begin
							step_ff <= 8'h00;
							cyc_ff <= 16'h0000;
							local_ff <= local_start;
							st_ff <= lss_pkg::lss_st_arm;
						end
					end
					lss_pkg::lss_st_arm: begin
						// [RULE_16] Wait for trigger-in unless immediate
						if (local_ff || tsrc_ff == lss_pkg::lss_trig_imm || trig_in) begin
							dwell_ff <= mem_tim[cur_idx][23:0];
							tmr_ff <= sdly_ff;
							st_ff <= lss_pkg::lss_st_delay;
						end
					end
					lss_pkg::lss_st_delay: begin
						// [RULE_17] Triggers ignored while busy
						if (tmr_ff != 24'h00_0000) begin
							tmr_ff <= tmr_ff - 24'h00_0001;
						end else begin
							// [RULE_13] Samples from window over period
							// [RULE_14] Point mode takes stored count
							smp_goal_ff <= hold_mode_select_ff ? mem_tim[cur_idx][31:24] + 16'h0000 :
								16'(win_time / 24'(sprd_ff));
							smp_ff <= 16'h0000;
							tmr_ff <= az_time_ff;
							st_ff <= az_ff ? lss_pkg::lss_st_zero : lss_pkg::lss_st_meas;
						end
					end
					lss_pkg::lss_st_zero: begin
						// [RULE_20] Reference and zero readings
						if (tmr_ff != 24'h00_0000) begin
							tmr_ff <= tmr_ff - 24'h00_0001;
						end else begin
							tmr_ff <= sdly_ff;
							st_ff <= lss_pkg::lss_st_meas;
						end
					end
					lss_pkg::lss_st_meas: begin
						// [RULE_02] Time hold until window
						// [RULE_03] Point hold until count
						if (smp_ff >= smp_goal_ff) begin
							st_ff <= lss_pkg::lss_st_done;
						end else if (sample_tick) begin
							smp_ff <= smp_ff + 16'h0001;
							st_ff <= az_ff ? lss_pkg::lss_st_zero : lss_pkg::lss_st_meas;
							tmr_ff <= az_time_ff;
						end
					end
					lss_pkg::lss_st_done: begin
						// [RULE_08] Repeat list cycle count times
						if (last_step) begin
							step_ff <= 8'h00;
							cyc_ff <= cyc_ff + 16'h0001;
							st_ff <= (cyc_ff + 16'h0001 >= cyc_cfg_ff) ? lss_pkg::lss_st_idle : lss_pkg::lss_st_wait;
						end else begin
							step_ff <= step_ff + 8'h01;
							st_ff <= lss_pkg::lss_st_wait;
						end
					end
					lss_pkg::lss_st_wait: begin
						// [RULE_05] Step mode rearms per step
						// [RULE_07] Sweep rearms only per cycle
						// [RULE_15] Immediate goes straight on
						if (sweep_ff && step_ff != 8'h00) begin
							dwell_ff <= mem_tim[cur_idx][23:0];
							tmr_ff <= sdly_ff;
							st_ff <= lss_pkg::lss_st_delay;
						end else begin
							st_ff <= lss_pkg::lss_st_arm;
						end
					end
					default: st_ff <= lss_pkg::lss_st_idle;
				endcase
			end
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// Outputs, all registered
	always_ff @(posedge core_clk) begin
		if (rst) begin
			meas_done <= 1'b0;
			running <= 1'b0;
			src_out <= '0;
			eff_trig_src <= 2'b00;
			cont_init <= 1'b0;
		end else if (clk_en) begin
			// [RULE_06] Step pulse after each step
			// [RULE_07] Sweep pulse after each cycle
			// [RULE_22] Single-cycle pulse
			meas_done <= st_ff == lss_pkg::lss_st_done && !stop_req && (!sweep_ff || last_step);
			running <= st_ff != lss_pkg::lss_st_idle && !stop_req;
			// [RULE_10] Local start forces immediate, continuous off
			eff_trig_src <= local_ff ? 2'(lss_pkg::lss_trig_imm) : 2'(tsrc_ff);
			cont_init <= 1'b0;
			if (st_ff == lss_pkg::lss_st_delay) begin
				src_out <= mem_src[cur_idx];
			end else if (st_ff != lss_pkg::lss_st_idle && (stop_req ||
				(st_ff == lss_pkg::lss_st_done && last_step && cyc_ff + 16'h0001 >= cyc_cfg_ff)) && zero_end_ff) begin
				// [RULE_04] Zero on finish
				src_out <= {`LSS_ZERO_VOLT, `LSS_ZERO_ILIM};
			end
		end
	end
endmodule : lss_list_step_sequencer

// ---- core/lss_params.svh ----
// List step sequencer constants: field positions, reset values, timing counts.
// Assumes inclusion by bare name from the package and the sequencer module.
`ifndef LSS_PARAMS_SVH
`define LSS_PARAMS_SVH
`define LSS_CLK_MHZ 125
`define LSS_LIST_MIN 4'h1
`define LSS_LIST_MAX 4'h9
`define LSS_LIST_DEMO 4'h0
`define LSS_PNT_W 8
`define LSS_TIME_W 24
`define LSS_CYC_W 16
`define LSS_SMP_W 16
`define LSS_ZERO_VOLT 16'h0000
`define LSS_ZERO_ILIM 16'h0064
`define LSS_MEM_DEPTH 256
`define LSS_ADDR_CTRL 12'h000
`define LSS_ADDR_CFG 12'h004
`define LSS_ADDR_SDLY 12'h008
`define LSS_ADDR_SPRD 12'h00C
`define LSS_ADDR_LIMIT 12'h010
`define LSS_ADDR_STAT 12'h014
`define LSS_ADDR_AZ 12'h018
`define LSS_ADDR_PNTS 12'h01C
`define LSS_ADDR_STEP 12'h400
`define LSS_CTRL_START 0
`define LSS_CTRL_ABORT 1
`define LSS_CFG_SWEEP 0
`define LSS_CFG_HOLD 1
`define LSS_CFG_ZERO 2
`define LSS_CFG_AZ 3
`define LSS_CFG_TSRC_LO 4
`define LSS_CFG_LIST_LO 8
`define LSS_CFG_CYC_LO 16
`endif

// ---- core/lss_pkg.sv ----
// List step sequencer types: states, trigger sources and the source output carrier.
// Assumes lss_params.svh is reachable on the include path.
`include "lss_params.svh"
package lss_pkg;
	typedef enum logic [1:0] {lss_trig_imm, lss_trig_ext, lss_trig_bus, lss_trig_man} lss_trig_e;
	typedef enum logic [2:0] {lss_st_idle, lss_st_arm, lss_st_delay, lss_st_zero, lss_st_meas, lss_st_done,
		lss_st_wait} lss_state_e;
	typedef struct packed {
		logic [15:0] volt;
		logic [15:0] ilim;
	} lss_src_s;
endpackage : lss_pkg

// ---- verification/lss_chk.sv ----
// Checker for the list step sequencer: port-level timing relations.
// Assumes it is bound to the sequencer and sees only its ports.
`timescale 1ns/10ps
module lss_chk (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	input wire logic clk_en,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	// Sequencer
	input wire logic output_on,
	input wire logic meas_done,
	input wire logic running,
	input wire logic cont_init
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	////////////////////////
	// Pulse and reset
	a_done_pulse: assert property (meas_done |=> !meas_done)
		else $error("meas_done wider than one cycle");
	a_reset_quiet: assert property (disable iff (1'b0) rst |=> !running && !meas_done && !pready)
		else $error("outputs active after reset");
	a_done_running: assert property (meas_done |-> $past(running))
		else $error("meas_done outside a run");
	// Output off must stop the run within two edges
	a_off_abort: assert property (running && !output_on |-> ##[1:2] !running)
		else $error("run kept going with output off");
	a_cont_off: assert property (!cont_init)
		else $error("continuous initiation set");
	////////////////////////
	// Bus answer, one wait-free access
	a_apb_answer: assert property (psel && !penable && clk_en |=> pready)
		else $error("no pready in access cycle");
	a_ready_single: assert property (pready |=> !pready)
		else $error("pready held two cycles");
	// Point count of list nine sits at 0x040, so the hole starts one word above it
	a_unmapped_err: assert property (pready && !pwrite && paddr > 12'h040 && paddr < 12'h400 |-> pslverr)
		else $error("unmapped read without error");
endmodule : lss_chk
bind lss_list_step_sequencer lss_chk u_chk (.core_clk(core_clk), .rst(rst), .clk_en(clk_en),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready),
	.pslverr(pslverr), .output_on(output_on), .meas_done(meas_done), .running(running),
	.cont_init(cont_init));

// ---- verification/lss_partner.sv ----
// Partner model: trigger source and listener on the measure-complete line.
// Assumes the bench gates triggers and sample ticks.
`timescale 1ns/10ps
module lss_partner (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Bench controls
	input wire logic trig_en,
	input wire logic tick_en,
	// Device side
	input wire logic meas_done,
	output logic trig_in,
	output logic sample_tick,
	output int done_cnt
);
	logic [3:0] div_ff;
	////////////////////////
	// Free divider for event timing
	always_ff @(posedge core_clk) begin
		div_ff <= rst ? 4'h0 : div_ff + 4'h1;
	end
	// trigger-in events
	// Fixed period, so some land in busy phases and must be dropped
	always_ff @(posedge core_clk) begin
		trig_in <= trig_en && !rst && div_ff == 4'hF;
		sample_tick <= tick_en && !rst && div_ff[0];
	end
	// Listener counts pulses on line 2
	always_ff @(posedge core_clk) begin
		done_cnt <= rst ? 0 : done_cnt + int'(meas_done);
	end
endmodule : lss_partner

// ---- verification/tb.sv ----
// Bench for the list step sequencer: APB master, pulse model, abort causes.
// Assumes the partner model supplies triggers and sample ticks.
`timescale 1ns/10ps
module tb;
	logic core_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, local_start = 0, output_on = 1;
	logic trig_en = 1, tick_en = 1, hot = 0, trig_in, sample_tick, meas_done, running, cont_init;
	logic pready, pslverr;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, seed = 32'h0000_2a7a;
	logic [31:0] w [3];
	logic [15:0] meas_value = 0;
	logic [1:0] eff_trig_src;
	lss_pkg::lss_src_s src_out;
	int err_count = 0, total_checks = 0, done_cnt, base;
	logic [31:0] exp_q [$];
	lss_list_step_sequencer dut (.core_clk(core_clk), .rst(rst), .clk_en(1'b1), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .local_start(local_start), .output_on(output_on),
		.trig_in(trig_in), .sample_tick(sample_tick), .meas_value(meas_value), .src_out(src_out),
		.meas_done(meas_done), .running(running), .eff_trig_src(eff_trig_src), .cont_init(cont_init));
	lss_partner u_partner (.core_clk(core_clk), .rst(rst), .trig_en(trig_en), .tick_en(tick_en),
		.meas_done(meas_done), .trig_in(trig_in), .sample_tick(sample_tick), .done_cnt(done_cnt));
	always #4 core_clk = ~core_clk;
	////////////////////////
	// Step of the random source
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Setup then access; held until pready is sampled high
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [32:0] exp);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1 && ++n < 50);
		if (!wr) chk({31'h0, pslverr}, {31'h0, exp[32]});
		if (!wr) chk(prdata, exp[31:0]);
		chk(32'(n < 50), 1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask : apb
	// Model: expected source word at every pulse, pulse count per run
	task automatic run(input logic [31:0] cfg, input logic loc);
		int n;
		n = 0;
		for (int c = 0; c < cfg[31:16]; c++)
			for (int i = cfg[0] ? 2 : 0; i < 3; i++)
				exp_q.push_back((cfg[2] && c == cfg[31:16] - 1 && i == 2) ? {`LSS_ZERO_VOLT, `LSS_ZERO_ILIM} : w[i]);
		base = done_cnt;
		apb(1, 12'h004, cfg, 0);
		if (!loc) apb(1, 12'h000, 32'h0000_0001, 0);
		local_start <= loc;
		@(posedge core_clk);
		local_start <= 1'b0;
		while (running !== 1'b1 && ++n < 100) @(posedge core_clk);
		chk(32'(n < 100), 1);
		if (loc) chk(32'(eff_trig_src), 0);
		while (running === 1'b1 && ++n < 20000) @(posedge core_clk);
		chk(32'(n < 20000), 1);
		repeat (4) @(posedge core_clk);
		chk(32'(done_cnt - base), cfg[0] ? cfg[31:16] : 3 * cfg[31:16]);
		chk(32'(exp_q.size()), 0);
	endtask : run
	task automatic conclude();
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : conclude
	////////////////////////
	// Random sample values; hot forces them over a low limit
	always @(posedge core_clk) begin
		seed <= lfsr(seed);
		meas_value <= {hot, seed[14:0]};
		if (meas_done === 1'b1 && exp_q.size() > 0) chk(src_out, exp_q.pop_front());
	end
	initial begin
		#400000;
		err_count++;
		conclude();
	end
	initial begin
		repeat (12) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		apb(0, 12'h004, 0, 33'h0_0001_0000);
		apb(0, 12'h014, 0, 0);
		apb(0, 12'h044, 0, 33'h1_0000_0000);
		for (int i = 0; i < 3; i++) begin
			w[i] = seed;
			apb(1, 12'h400 + 12'(8 * i), w[i], 0);
			apb(1, 12'h404 + 12'(8 * i), 32'h0200_0020, 0);
		end
		apb(1, 12'h008, 32'h0000_0002, 0);
		apb(1, 12'h00C, 32'h0000_0001, 0);
		apb(1, 12'h018, 32'h0000_0004, 0);
		apb(1, 12'h01C, 32'h0000_0003, 0);
		apb(1, 12'h010, 32'h0000_FFFF, 0);
		run(32'h0001_0012, 0);
		run(32'h0002_001F, 0);
		chk(src_out, {`LSS_ZERO_VOLT, `LSS_ZERO_ILIM});
		run(32'h0001_0010, 0);
		chk(src_out, w[2]);
		trig_en <= 1'b0;
		run(32'h0001_0012, 1);
		trig_en <= 1'b1;
		// Output off, abort command, limit exceeded
		for (int i = 0; i < 3; i++) begin
			apb(1, 12'h010, i == 2 ? 32'h0000_0010 : 32'h0000_FFFF, 0);
			tick_en <= (i == 2);
			hot <= (i == 2);
			base = done_cnt;
			apb(1, 12'h000, 32'h0000_0001, 0);
			repeat (40) @(posedge core_clk);
			output_on <= (i != 0);
			if (i == 1) apb(1, 12'h000, 32'h0000_0002, 0);
			repeat (20) @(posedge core_clk);
			chk(32'(running), 0);
			chk(32'(done_cnt - base), 0);
			output_on <= 1'b1;
		end
		conclude();
	end
endmodule : tb
